// >>> dbgid_pkg.sv
// shared constants for the debug access id gate
package dbgid_pkg;
  localparam int ID_BYTES = 10;
  localparam logic [27:0] ID_FIRST_ADDR = 28'h0000070;
  localparam logic [27:0] ID_LAST_ADDR = 28'h0000079;
  localparam logic [7:0] ID_ERASED_BYTE = 8'hff;
  localparam int ENABLE_FLAG_BIT = 7;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h01;
  localparam logic [7:0] CMD_FLASH_READ = 8'h02;
  localparam logic [7:0] CMD_RUN = 8'h03;
  localparam logic [7:0] CMD_BREAK = 8'h04;
  localparam logic [7:0] RESP_OK = 8'ha5;
  localparam logic [7:0] RESP_DENIED = 8'h5a;
  localparam int BYTE_BITS = 8;
endpackage

// >>> dbgid_id_store.sv
// stored identification code region with registered read data
`timescale 1ns/1ps
`default_nettype none
module dbgid_id_store #(
  parameter int DEPTH = 10
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic prog_we,
  input wire logic [3:0] prog_addr,
  input wire logic [7:0] prog_data,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [7:0] flag_byte
);
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rd_data_reg;
  logic [7:0] flag_reg;

  // erased region reads all ones until programmed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data_reg <= dbgid_pkg::ID_ERASED_BYTE;
      flag_reg <= dbgid_pkg::ID_ERASED_BYTE;
    end else begin
      rd_data_reg <= mem_reg[rd_addr];
      flag_reg <= mem_reg[DEPTH-1];
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          mem_reg[i] <= dbgid_pkg::ID_ERASED_BYTE;
        end else if (prog_we && (prog_addr == 4'(i))) begin
          mem_reg[i] <= prog_data;
        end
      end
    end
  endgenerate

  assign rd_data = rd_data_reg;
  assign flag_byte = flag_reg;
endmodule
`default_nettype wire

// >>> dbgid_gate.sv
// debug access id gate: serial debug link, id compare and unlock control
// Operation
// - debugger's ten id bytes are compared one by one with stored region bytes.
// - a full match unlocks flash reads and emulator operation.
// - unprogrammed id region holds all ones; debugger must send all ones.
// - bit seven of last stored id byte is the emulator use enable.
// - match with enable flag zero still refuses debugging.
// - link uses serial in, serial out, serial clock and handshake line.
// - forced break ignored while debug serial channel interrupts are masked.
`timescale 1ns/1ps
`default_nettype none
module dbgid_gate (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_in,
  output logic debug_serial_out,
  output logic debug_handshake,
  input wire logic serial_irq_masked,
  input wire logic prog_we,
  input wire logic [3:0] prog_addr,
  input wire logic [7:0] prog_data,
  output logic unlocked,
  output logic flash_read_req,
  output logic run_req,
  output logic break_req
);
  typedef enum {ST_CMD, ST_ID, ST_CHECK, ST_REPLY} dbgid_state_t;

  logic [2:0] sck_sync_reg, sck_sync_next;
  logic [1:0] sdi_sync_reg, sdi_sync_next;
  logic [1:0] msk_sync_reg, msk_sync_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic sdo_reg, sdo_next;
  logic hs_reg, hs_next;
  logic byte_done;
  dbgid_state_t st_reg, st_next;
  logic [3:0] idx_reg, idx_next;
  logic match_reg, match_next;
  logic unlocked_reg, unlocked_next;
  logic frd_reg, frd_next, run_reg, run_next, brk_reg, brk_next;
  logic [7:0] mem_rd;
  logic [7:0] flag_byte;
  logic sck_rise, sck_fall;

  function automatic logic is_gated_cmd(input logic [7:0] c);
    return (c == dbgid_pkg::CMD_FLASH_READ) || (c == dbgid_pkg::CMD_RUN) || (c == dbgid_pkg::CMD_BREAK);
  endfunction

  dbgid_id_store #(.DEPTH(dbgid_pkg::ID_BYTES)) u_store (
    .ref_clk(ref_clk),
    .srst(srst),
    .prog_we(prog_we),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .rd_addr(idx_reg),
    .rd_data(mem_rd),
    .flag_byte(flag_byte)
  );

  assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
  assign sck_fall = !sck_sync_reg[1] && sck_sync_reg[2];
  assign byte_done = sck_rise && (bit_cnt_reg == 3'(dbgid_pkg::BYTE_BITS - 1));

  // link side: sample on rising serial clock, shift out on falling, msb first
  always_comb begin
    sck_sync_next = {sck_sync_reg[1:0], debug_serial_clock};
    sdi_sync_next = {sdi_sync_reg[0], debug_serial_in};
    msk_sync_next = {msk_sync_reg[0], serial_irq_masked};
    bit_cnt_next = bit_cnt_reg;
    rx_sh_next = rx_sh_reg;
    tx_sh_next = tx_sh_reg;
    sdo_next = sdo_reg;
    hs_next = hs_reg;
    if (sck_rise) begin
      rx_sh_next = {rx_sh_reg[6:0], sdi_sync_reg[1]};
      bit_cnt_next = bit_cnt_reg + 3'h1;
    end
    if (sck_fall) begin
      sdo_next = tx_sh_reg[7];
      tx_sh_next = {tx_sh_reg[6:0], 1'b0};
    end
    // handshake low while a byte is being checked (busy)
    if (byte_done) begin
      hs_next = 1'b0;
    end else if ((st_reg == ST_REPLY) || (st_reg == ST_ID)) begin
      // id bytes before the last get no reply, so ready returns at once
      hs_next = 1'b1;
    end
    if (st_reg == ST_REPLY) begin
      tx_sh_next = unlocked_next ? dbgid_pkg::RESP_OK : dbgid_pkg::RESP_DENIED;
    end
  end

  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    match_next = match_reg;
    unlocked_next = unlocked_reg;
    frd_next = 1'b0;
    run_next = 1'b0;
    brk_next = 1'b0;
    case (st_reg)
      ST_CMD: begin
        if (byte_done) begin
          st_next = ST_REPLY;
          if ({rx_sh_reg[6:0], sdi_sync_reg[1]} == dbgid_pkg::CMD_ID_ENTRY) begin
            st_next = ST_ID;
            idx_next = 4'h0;
            match_next = 1'b1;
            unlocked_next = 1'b0;
          end else if (is_gated_cmd({rx_sh_reg[6:0], sdi_sync_reg[1]}) && unlocked_reg) begin
            frd_next = ({rx_sh_reg[6:0], sdi_sync_reg[1]} == dbgid_pkg::CMD_FLASH_READ);
            run_next = ({rx_sh_reg[6:0], sdi_sync_reg[1]} == dbgid_pkg::CMD_RUN);
            brk_next = ({rx_sh_reg[6:0], sdi_sync_reg[1]} == dbgid_pkg::CMD_BREAK) && !msk_sync_reg[1];
          end
        end
      end
      ST_ID: begin
        if (byte_done) begin
          // store read data for idx_reg is ready since the byte took many cycles
          if ({rx_sh_reg[6:0], sdi_sync_reg[1]} != mem_rd) begin
            match_next = 1'b0;
          end
          if (idx_reg == 4'(dbgid_pkg::ID_BYTES - 1)) begin
            st_next = ST_CHECK;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end
      end
      ST_CHECK: begin
        unlocked_next = match_reg && flag_byte[dbgid_pkg::ENABLE_FLAG_BIT];
        idx_next = 4'h0;
        st_next = ST_REPLY;
      end
      ST_REPLY: begin
        st_next = ST_CMD;
      end
      default: begin
        st_next = ST_CMD;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sck_sync_reg <= 3'h0;
      sdi_sync_reg <= 2'h0;
      msk_sync_reg <= 2'h3;
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      sdo_reg <= 1'b0;
      hs_reg <= 1'b1;
      st_reg <= ST_CMD;
      idx_reg <= 4'h0;
      match_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      frd_reg <= 1'b0;
      run_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      sck_sync_reg <= sck_sync_next;
      sdi_sync_reg <= sdi_sync_next;
      msk_sync_reg <= msk_sync_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      sdo_reg <= sdo_next;
      hs_reg <= hs_next;
      st_reg <= st_next;
      idx_reg <= idx_next;
      match_reg <= match_next;
      unlocked_reg <= unlocked_next;
      frd_reg <= frd_next;
      run_reg <= run_next;
      brk_reg <= brk_next;
    end
  end

  assign debug_serial_out = sdo_reg;
  assign debug_handshake = hs_reg;
  assign unlocked = unlocked_reg;
  assign flash_read_req = frd_reg;
  assign run_req = run_reg;
  assign break_req = brk_reg;

  a_locked_blocks: assert property (@(posedge ref_clk) disable iff (srst)
    !unlocked_reg |=> !(frd_reg || run_reg || brk_reg)) else $error("gated command while locked");
  a_flag_zero_denies: assert property (@(posedge ref_clk) disable iff (srst)
    (st_reg == ST_CHECK) && !flag_byte[dbgid_pkg::ENABLE_FLAG_BIT] |=> !unlocked_reg)
    else $error("unlocked with enable flag clear");
  a_match_unlocks: assert property (@(posedge ref_clk) disable iff (srst)
    (st_reg == ST_CHECK) && match_reg && flag_byte[dbgid_pkg::ENABLE_FLAG_BIT] |=> unlocked_reg)
    else $error("matching id did not unlock");
  a_mismatch_clears: assert property (@(posedge ref_clk) disable iff (srst)
    (st_reg == ST_ID) && byte_done && ({rx_sh_reg[6:0], sdi_sync_reg[1]} != mem_rd) |=> !match_reg)
    else $error("byte mismatch not recorded");
  a_masked_no_break: assert property (@(posedge ref_clk) disable iff (srst)
    msk_sync_reg[1] |=> !brk_reg) else $error("break taken while masked");
  a_entry_relocks: assert property (@(posedge ref_clk) disable iff (srst)
    (st_reg == ST_CMD) && (st_next == ST_ID) |=> !unlocked_reg && (idx_reg == 4'h0))
    else $error("id entry did not relock");
  a_check_replies: assert property (@(posedge ref_clk) disable iff (srst)
    (st_reg == ST_CHECK) |=> (st_reg == ST_REPLY) ##1 (st_reg == ST_CMD) && hs_reg)
    else $error("reply sequence broken");
  a_id_byte_ready: assert property (@(posedge ref_clk) disable iff (srst)
    (st_reg == ST_ID) && byte_done && (idx_reg != 4'(dbgid_pkg::ID_BYTES - 1)) |=> ##1 hs_reg)
    else $error("handshake not back after id byte");
  a_unlock_stable: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(unlocked_reg) |-> $past(st_reg) == ST_CHECK) else $error("unlock outside check");
  c_unlock: cover property (@(posedge ref_clk) disable iff (srst) $rose(unlocked_reg));
  c_flash_read: cover property (@(posedge ref_clk) disable iff (srst) frd_reg);
  c_break: cover property (@(posedge ref_clk) disable iff (srst) brk_reg);
  c_denied: cover property (@(posedge ref_clk) disable iff (srst) (st_reg == ST_CHECK) && !match_reg);
endmodule
`default_nettype wire

// >>> dbgid_emulator.sv
// behavioural debug emulator driving the serial debug link
`timescale 1ns/1ps
`default_nettype none
module dbgid_emulator (
  output logic debug_serial_clock,
  output logic debug_serial_in,
  input wire logic debug_serial_out,
  input wire logic debug_handshake
);
  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b0;
  end
  // one byte msb first, clock idle low, 80 ns period
  task automatic send_byte(input logic [7:0] tx, output logic ok, output logic [7:0] rx);
    int n;
    rx = 8'h00;
    for (n = 0; n < 400 && debug_handshake !== 1'b1; n++) #8;
    ok = (debug_handshake === 1'b1); // waits for ready
    #3;
    for (n = 7; n >= 0; n--) begin
      debug_serial_in = tx[n];
      #40 debug_serial_clock = 1'b1;
      // reply bit taken at the rising serial clock
      rx = {rx[6:0], debug_serial_out};
      #40 debug_serial_clock = 1'b0;
    end
    // released line shows the inverse, not the last bit
    debug_serial_in = ~tx[0];
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the debug access id gate
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module testbench;
  logic ref_clk, srst, serial_irq_masked, prog_we;
  logic [3:0] prog_addr;
  logic [7:0] prog_data;
  wire logic sclk, sin, sout, hs, unlocked, rd_req, run_req, brk_req;
  int fails = 0, checks_done = 0, rd_cnt = 0, run_cnt = 0, brk_cnt = 0;
  logic [7:0] last_rx;
  localparam logic [79:0] PAT = 80'h80_13_57_9b_df_24_68_ac_e0_5a;

  dbgid_gate dut_u (.ref_clk(ref_clk), .srst(srst), .debug_serial_clock(sclk), .debug_serial_in(sin),
    .debug_serial_out(sout), .debug_handshake(hs), .serial_irq_masked(serial_irq_masked),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data), .unlocked(unlocked),
    .flash_read_req(rd_req), .run_req(run_req), .break_req(brk_req));
  dbgid_emulator emu_u (.debug_serial_clock(sclk), .debug_serial_in(sin), .debug_serial_out(sout),
    .debug_handshake(hs));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rd_req === 1'b1) rd_cnt++;
    if (run_req === 1'b1) run_cnt++;
    if (brk_req === 1'b1) brk_cnt++;
  end

  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] b);
    logic ok;
    emu_u.send_byte(b, ok, last_rx);
    `CHK("handshake", 1'b1, ok)
    if (ok !== 1'b1) test_done();
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic cmd_check(input logic [7:0] c, input int e_rd, input int e_run, input int e_brk);
    int r0, u0, b0;
    r0 = rd_cnt;
    u0 = run_cnt;
    b0 = brk_cnt;
    xfer(c);
    `CHK("flash_read_req", e_rd, rd_cnt - r0)
    `CHK("run_req", e_run, run_cnt - u0)
    `CHK("break_req", e_brk, brk_cnt - b0)
  endtask
  // unknown filler command carries back the reply of the previous transfer
  task automatic reply_check(input logic [7:0] exp);
    cmd_check(8'h00, 0, 0, 0);
    `CHK("reply byte", exp, last_rx)
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("unlocked after reset", 1'b0, unlocked)
    `CHK("handshake after reset", 1'b1, hs)
    cmd_check(dbgid_pkg::CMD_RUN, 0, 0, 0);
  endtask
  // command first, then bytes of index 0 to 9
  task automatic id_entry(input logic [79:0] id);
    xfer(dbgid_pkg::CMD_ID_ENTRY);
    for (int i = 0; i < 10; i++) xfer(id[8*i +: 8]);
  endtask
  task automatic program_id(input logic [79:0] v);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      prog_we <= 1'b1;
      prog_addr <= i[3:0];
      prog_data <= v[8*i +: 8];
    end
    @(posedge ref_clk);
    prog_we <= 1'b0;
  endtask

  task automatic t_locked();
    `CHK("unlocked", 1'b0, unlocked)
    `CHK("handshake idle", 1'b1, hs)
    cmd_check(dbgid_pkg::CMD_FLASH_READ, 0, 0, 0);
    cmd_check(dbgid_pkg::CMD_RUN, 0, 0, 0);
    cmd_check(dbgid_pkg::CMD_BREAK, 0, 0, 0);
    reply_check(dbgid_pkg::RESP_DENIED);
  endtask
  task automatic t_erased();
    id_entry({10{dbgid_pkg::ID_ERASED_BYTE}});
    `CHK("unlocked", 1'b1, unlocked)
    reply_check(dbgid_pkg::RESP_OK);
    cmd_check(dbgid_pkg::CMD_FLASH_READ, 1, 0, 0);
    cmd_check(dbgid_pkg::CMD_RUN, 0, 1, 0);
    cmd_check(dbgid_pkg::CMD_BREAK, 0, 0, 1);
    @(posedge ref_clk);
    serial_irq_masked <= 1'b1;
    cmd_check(dbgid_pkg::CMD_BREAK, 0, 0, 0);
    cmd_check(dbgid_pkg::CMD_RUN, 0, 1, 0);
    @(posedge ref_clk);
    serial_irq_masked <= 1'b0;
  endtask
  task automatic t_mismatch();
    program_id(PAT);
    // one wrong bit in the first and in the last byte
    id_entry(PAT ^ 80'h1);
    `CHK("unlocked first byte bad", 1'b0, unlocked)
    reply_check(dbgid_pkg::RESP_DENIED);
    id_entry(PAT ^ (80'h1 << 72));
    `CHK("unlocked last byte bad", 1'b0, unlocked)
    id_entry(PAT);
    `CHK("unlocked match", 1'b1, unlocked)
  endtask
  task automatic t_flag_zero();
    program_id(PAT & ~(80'h1 << 79));
    id_entry(PAT & ~(80'h1 << 79));
    `CHK("unlocked flag zero", 1'b0, unlocked)
    reply_check(dbgid_pkg::RESP_DENIED);
    cmd_check(dbgid_pkg::CMD_FLASH_READ, 0, 0, 0);
  endtask

  initial begin
    srst = 1'b1;
    serial_irq_masked = 1'b0;
    prog_we = 1'b0;
    prog_addr = 4'h0;
    prog_data = 8'h00;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_locked();
    t_erased();
    t_reset();
    t_mismatch();
    t_flag_zero();
    test_done();
  end
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
